// file: inc/fp_mode_control_defines.vh
`ifndef FP_MODE_CONTROL_DEFINES_VH
`define FP_MODE_CONTROL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SIMD_CSW 8'h00
`define OFS_X87_CW 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_ENABLE 8'h0c
`define OFS_INT_CLEAR 8'h10
`define OFS_SLOW_COUNT 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CSW_FLUSH_BIT 0
`define CSW_ZAP_BIT 1
`define CSW_RESET 2'h0
`define X87_CW_RESET 16'h0000
`define X87_CW_FAST_MASK 16'h1f00
`define RC_LO 10
`define RC_HI 11
`define RC_TRUNCATE 2'h3
`define EXT_EXP_MAX 18'h07ffe
`define INT_BITS 6
`define EV_FLUSH 0
`define EV_DAZ 1
`define EV_OVF 2
`define EV_SLOW_CW 3
`define EV_X87_OVF 4
`define EV_X87_UNF 5

// ----------------------------------------
// Timing counts in cycles
// ----------------------------------------
`define PIPE_DEPTH 20
`define CSW_READ_LAT 10

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/fp_lane_zero.v
`timescale 1ns/1ps
`include "fp_mode_control_defines.vh"

module fp_lane_zero (
    input wire [63:0] value,
    input wire is_double,
    input wire zap_denorm,
    input wire [1:0] force_zero,
    output wire [63:0] result,
    output wire hit
);
    // ----------------------------------------
    // Denormal detection
    // ----------------------------------------
    function den_s;
        input [31:0] v;
        begin
            den_s = (v[30:23] == 8'h00) && (v[22:0] != 23'h000000);
        end
    endfunction

    function den_d;
        input [63:0] v;
        begin
            den_d = (v[62:52] == 11'h000) && (v[51:0] != 52'h0);
        end
    endfunction

    wire [1:0] zero_s;
    wire [63:0] res_s;
    wire zero_d;

    // Per single lane: signed zero when denormal and zapping, or forced
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lane
            assign zero_s[g] = (zap_denorm && den_s(value[32*g+31:32*g])) || force_zero[g];
            assign res_s[32*g+31:32*g] = zero_s[g] ? {value[32*g+31], 31'h0} :
                value[32*g+31:32*g];
        end
    endgenerate

    // Double lane shares zap_denorm but takes only force_zero[0]
    assign zero_d = (zap_denorm && den_d(value)) || force_zero[0];
    assign result = is_double ? (zero_d ? {value[63], 63'h0} : value) : res_s;
    assign hit = is_double ? zero_d : (zero_s != 2'h0);
endmodule

// file: rtl/fp_mode_control.v
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fp_mode_control_defines.vh"

module fp_mode_control #(
    parameter PIPE_DEPTH = `PIPE_DEPTH,
    parameter CSW_READ_LAT = `CSW_READ_LAT
) (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire op_valid,
    input wire op_double,
    input wire [63:0] op_a,
    input wire [63:0] op_b,
    output reg opc_valid_q,
    output reg [63:0] opc_a_q,
    output reg [63:0] opc_b_q,
    input wire res_valid,
    input wire res_double,
    input wire [63:0] res_value,
    input wire [1:0] res_underflow,
    input wire res_overflow,
    output reg resc_valid_q,
    output reg [63:0] resc_value_q,
    input wire cw_load_valid,
    input wire [15:0] cw_load_value,
    output reg cw_load_ready_q,
    output reg [15:0] x87_cw_q,
    input wire cvt_valid,
    input wire cvt_truncate,
    output reg cvt_round_valid_q,
    output reg [1:0] cvt_round_q,
    input wire x87_res_valid,
    input wire [17:0] x87_res_exp,
    output reg x87_ovf_q,
    output reg x87_unf_q,
    input wire pipe_empty,
    output reg issue_stall_q,
    output reg irq_q
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    localparam [2:0] R_CSW = 3'h0;
    localparam [2:0] R_X87 = 3'h1;
    localparam [2:0] R_STAT = 3'h2;
    localparam [2:0] R_EN = 3'h3;
    localparam [2:0] R_CLR = 3'h4;
    localparam [2:0] R_SLOW = 3'h5;
    localparam [2:0] R_NONE = 3'h7;
    localparam [7:0] PD_M1 = PIPE_DEPTH[7:0] - 8'h01;
    localparam [7:0] RL_M1 = CSW_READ_LAT[7:0] - 8'h01;

    function [2:0] reg_index;
        input [7:0] a;
        begin
            case (a)
                `OFS_SIMD_CSW: reg_index = R_CSW;
                `OFS_X87_CW: reg_index = R_X87;
                `OFS_INT_STATUS: reg_index = R_STAT;
                `OFS_INT_ENABLE: reg_index = R_EN;
                `OFS_INT_CLEAR: reg_index = R_CLR;
                `OFS_SLOW_COUNT: reg_index = R_SLOW;
                default: reg_index = R_NONE;
            endcase
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [1:0] csw_q;
    reg [1:0] csw_pend_q;
    reg ser_q;
    reg [`INT_BITS-1:0] status_q;
    reg [`INT_BITS-1:0] enable_q;
    reg [15:0] slow_count_q;
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg rd_busy_q;
    reg [7:0] rd_cnt_q;
    reg [7:0] rd_addr_q;
    reg [15:0] alt_cw_q;
    reg alt_valid_q;
    reg [7:0] busy_cnt_q;
    reg [`INT_BITS-1:0] clr_d;
    reg [`INT_BITS-1:0] ev_d;
    reg [31:0] rdata_d;
    reg cw_fast_d;
    reg cw_same_d;

    wire flush_on = csw_q[`CSW_FLUSH_BIT];
    wire zap_on = csw_q[`CSW_ZAP_BIT];
    wire [63:0] a_fix;
    wire [63:0] b_fix;
    wire [63:0] r_fix;
    wire a_hit;
    wire b_hit;
    wire r_hit;
    wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid && !ser_q;
    wire cw_take = cw_load_valid && cw_load_ready_q;
    wire [15:0] cw_diff = cw_load_value ^ x87_cw_q;

    // ----------------------------------------
    // Operand and result conditioning
    // ----------------------------------------
    // Operands zeroed only when denormal-as-zero is on
    fp_lane_zero u_opa (
        .value(op_a),
        .is_double(op_double),
        .zap_denorm(zap_on),
        .force_zero(2'h0),
        .result(a_fix),
        .hit(a_hit)
    );

    fp_lane_zero u_opb (
        .value(op_b),
        .is_double(op_double),
        .zap_denorm(zap_on),
        .force_zero(2'h0),
        .result(b_fix),
        .hit(b_hit)
    );

    // Results flushed only when flush mode is on
    fp_lane_zero u_res (
        .value(res_value),
        .is_double(res_double),
        .zap_denorm(flush_on),
        .force_zero(flush_on ? res_underflow : 2'h0),
        .result(r_fix),
        .hit(r_hit)
    );

    // Datapath stage: one cycle for every case, overflow included
    always @(posedge clk) begin
        if (reset) begin
            opc_valid_q <= 1'b0;
            opc_a_q <= 64'h0;
            opc_b_q <= 64'h0;
            resc_valid_q <= 1'b0;
            resc_value_q <= 64'h0;
        end else if (ce) begin
            opc_valid_q <= op_valid;
            opc_a_q <= a_fix;
            opc_b_q <= b_fix;
            resc_valid_q <= res_valid;
            resc_value_q <= r_fix;
        end
    end

    // ----------------------------------------
    // Control word fast path classification
    // ----------------------------------------
    // Fast when unchanged, or when returning to the remembered partner value
    always @* begin
        cw_same_d = (cw_load_value == x87_cw_q);
        cw_fast_d = cw_same_d || (alt_valid_q && (cw_load_value == alt_cw_q) &&
            ((cw_diff & ~`X87_CW_FAST_MASK) == 16'h0000));
    end

    // Load path with remembered pair and slow-load busy counter
    always @(posedge clk) begin
        if (reset) begin
            x87_cw_q <= `X87_CW_RESET;
            alt_cw_q <= `X87_CW_RESET;
            alt_valid_q <= 1'b0;
            busy_cnt_q <= 8'h00;
            cw_load_ready_q <= 1'b1;
            slow_count_q <= 16'h0000;
        end else if (ce) begin
            if (cw_take) begin
                if (!cw_fast_d) begin
                    alt_cw_q <= x87_cw_q;
                    alt_valid_q <= ((cw_diff & ~`X87_CW_FAST_MASK) == 16'h0000);
                    x87_cw_q <= cw_load_value;
                    busy_cnt_q <= PD_M1;
                    cw_load_ready_q <= 1'b0;
                    slow_count_q <= slow_count_q + 16'h0001;
                end else if (!cw_same_d) begin
                    alt_cw_q <= x87_cw_q;
                    x87_cw_q <= cw_load_value;
                end
            end else if (!cw_load_ready_q) begin
                if (busy_cnt_q == 8'h00) begin
                    cw_load_ready_q <= 1'b1;
                end else begin
                    busy_cnt_q <= busy_cnt_q - 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Legacy stack range and conversion rounding
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            x87_ovf_q <= 1'b0;
            x87_unf_q <= 1'b0;
            cvt_round_valid_q <= 1'b0;
            cvt_round_q <= 2'h0;
        end else if (ce) begin
            x87_ovf_q <= x87_res_valid && !x87_res_exp[17] &&
                (x87_res_exp > `EXT_EXP_MAX);
            x87_unf_q <= x87_res_valid && (x87_res_exp[17] || x87_res_exp == 18'h0);
            cvt_round_valid_q <= cvt_valid;
            cvt_round_q <= cvt_truncate ? `RC_TRUNCATE : x87_cw_q[`RC_HI:`RC_LO];
        end
    end

    // ----------------------------------------
    // Event collection and interrupt
    // ----------------------------------------
    always @* begin
        ev_d = {`INT_BITS{1'b0}};
        ev_d[`EV_FLUSH] = res_valid && r_hit;
        ev_d[`EV_DAZ] = op_valid && (a_hit || b_hit);
        ev_d[`EV_OVF] = res_valid && res_overflow;
        ev_d[`EV_SLOW_CW] = cw_take && !cw_fast_d;
        ev_d[`EV_X87_OVF] = x87_ovf_q;
        ev_d[`EV_X87_UNF] = x87_unf_q;
        clr_d = {`INT_BITS{1'b0}};
        if (wr_fire && reg_index(aw_addr_q) == R_CLR && w_strb_q[0]) begin
            clr_d = w_data_q[`INT_BITS-1:0];
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always @(posedge clk) begin
        if (reset) begin
            status_q <= {`INT_BITS{1'b0}};
            irq_q <= 1'b0;
        end else if (ce) begin
            status_q <= (status_q & ~clr_d) | ev_d;
            irq_q <= (((status_q & ~clr_d) | ev_d) & enable_q) != {`INT_BITS{1'b0}};
        end
    end

    // ----------------------------------------
    // Register write channel
    // ----------------------------------------
    // Mode register writes wait for the pipe to drain before taking effect
    always @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            csw_q <= `CSW_RESET;
            csw_pend_q <= `CSW_RESET;
            ser_q <= 1'b0;
            issue_stall_q <= 1'b0;
            enable_q <= {`INT_BITS{1'b0}};
        end else if (ce) begin
            if (s_axi_awready && s_axi_awvalid) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bresp <= `RESP_OKAY;
                case (reg_index(aw_addr_q))
                    R_CSW: begin
                        csw_pend_q <= w_strb_q[0] ? w_data_q[1:0] : csw_q;
                        ser_q <= 1'b1;
                        issue_stall_q <= 1'b1;
                    end
                    R_EN: begin
                        if (w_strb_q[0]) begin
                            enable_q <= w_data_q[`INT_BITS-1:0];
                        end
                        s_axi_bvalid <= 1'b1;
                    end
                    R_X87, R_STAT, R_CLR, R_SLOW: begin
                        s_axi_bvalid <= 1'b1;
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                        s_axi_bvalid <= 1'b1;
                    end
                endcase
            end
            if (ser_q && pipe_empty) begin
                csw_q <= csw_pend_q;
                ser_q <= 1'b0;
                issue_stall_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Register read channel
    // ----------------------------------------
    always @* begin
        case (reg_index(rd_addr_q))
            R_CSW: rdata_d = {30'h0, csw_q};
            R_X87: rdata_d = {16'h0, x87_cw_q};
            R_STAT: rdata_d = {{(32-`INT_BITS){1'b0}}, status_q};
            R_EN: rdata_d = {{(32-`INT_BITS){1'b0}}, enable_q};
            R_SLOW: rdata_d = {16'h0, slow_count_q};
            default: rdata_d = 32'h0;
        endcase
    end

    // Mode register reads take the long latency, others answer next cycle
    always @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
            rd_busy_q <= 1'b0;
            rd_cnt_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else if (ce) begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                rd_busy_q <= 1'b1;
                rd_addr_q <= s_axi_araddr;
                rd_cnt_q <= (reg_index(s_axi_araddr) == R_CSW) ? RL_M1 : 8'h00;
            end
            if (rd_busy_q) begin
                if (rd_cnt_q == 8'h00) begin
                    rd_busy_q <= 1'b0;
                    s_axi_rvalid <= 1'b1;
                    s_axi_rdata <= rdata_d;
                    s_axi_rresp <= (reg_index(rd_addr_q) == R_NONE ||
                        reg_index(rd_addr_q) == R_CLR) ? `RESP_SLVERR : `RESP_OKAY;
                end else begin
                    rd_cnt_q <= rd_cnt_q - 8'h01;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// file: tb/fp_mode_control_properties.sv
`timescale 1ns/1ps
`include "fp_mode_control_defines.vh"

// ----------------------------------------
// Port timing checks for the mode control block
// ----------------------------------------
module fp_mode_control_properties #(
    parameter PIPE_DEPTH = 20
) (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire op_valid,
    input wire op_double,
    input wire [63:0] op_a,
    input wire opc_valid_q,
    input wire [63:0] opc_a_q,
    input wire res_valid,
    input wire res_double,
    input wire [63:0] res_value,
    input wire res_overflow,
    input wire resc_valid_q,
    input wire [63:0] resc_value_q,
    input wire cw_load_valid,
    input wire [15:0] cw_load_value,
    input wire cw_load_ready_q,
    input wire [15:0] x87_cw_q,
    input wire cvt_valid,
    input wire cvt_truncate,
    input wire cvt_round_valid_q,
    input wire [1:0] cvt_round_q,
    input wire x87_res_valid,
    input wire [17:0] x87_res_exp,
    input wire x87_ovf_q
);
    wire [1:0] cw_round = x87_cw_q[11:10];
    wire res_sign = res_value[63];
    reg [7:0] low_q;

    // Count the cycles the load port is held off
    always @(posedge clk) begin
        if (reset)
            low_q <= 8'h00;
        else if (ce)
            low_q <= cw_load_ready_q ? 8'h00 : low_q + 8'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !ce);

    AST_OPC_PASS: assert property (
        op_valid && op_double && op_a[62:52] != 11'h000 |=> opc_a_q == $past(op_a))
        else $error("normal operand altered");
    AST_FLUSH_SIGN: assert property (
        res_valid && res_double |=> resc_valid_q && resc_value_q[63] == $past(res_sign))
        else $error("result sign lost");
    AST_OVF_PASS: assert property (
        res_valid && res_double && res_overflow |=> resc_value_q == $past(res_value))
        else $error("masked overflow result altered");
    AST_CW_SLOW_LEN: assert property (
        $rose(cw_load_ready_q) && !$past(reset) |-> low_q == PIPE_DEPTH)
        else $error("slow load penalty length wrong");
    AST_CW_OUTSIDE: assert property (
        cw_load_valid && cw_load_ready_q && ((cw_load_value ^ x87_cw_q) & 16'he0ff) != 16'h0000
        |=> !cw_load_ready_q ##1 !cw_load_ready_q)
        else $error("outside bit change not slow");
    AST_CVT_TRUNC: assert property (
        cvt_valid && cvt_truncate |=> cvt_round_valid_q && cvt_round_q == `RC_TRUNCATE)
        else $error("truncating convert used wrong rounding");
    AST_CVT_RC: assert property (
        cvt_valid && !cvt_truncate |=> cvt_round_valid_q && cvt_round_q == $past(cw_round))
        else $error("convert ignored control word rounding");
    AST_X87_OVF: assert property (
        x87_res_valid |=> x87_ovf_q == ($signed($past(x87_res_exp)) > $signed(18'h07ffe)))
        else $error("extended overflow flag wrong");
    AST_CSW_READ: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_SIMD_CSW
        |=> !s_axi_rvalid [*8] ##[1:40] s_axi_rvalid)
        else $error("mode word read too fast or missing");

    COV_SLOW_DONE: cover property ($rose(cw_load_ready_q));
    COV_OVF: cover property (res_valid && res_overflow);
    COV_CSW_RD: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00);
endmodule

bind fp_mode_control fp_mode_control_properties #(.PIPE_DEPTH(PIPE_DEPTH)) props_i (.*);

// file: tb/fp_mode_control_tb.sv
`timescale 1ns/1ps
`include "fp_mode_control_defines.vh"

module fp_mode_control_tb;
    logic clk, reset, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, res_underflow, cvt_round_q;
    logic op_valid, op_double, opc_valid_q, res_valid, res_double, res_overflow, resc_valid_q;
    logic [63:0] op_a, op_b, opc_a_q, opc_b_q, res_value, resc_value_q;
    logic cw_load_valid, cw_load_ready_q, cvt_valid, cvt_truncate, cvt_round_valid_q;
    logic [15:0] cw_load_value, x87_cw_q;
    logic x87_res_valid, x87_ovf_q, x87_unf_q, pipe_empty, issue_stall_q, irq_q;
    logic [17:0] x87_res_exp;
    logic [15:0] cwv [12] = '{16'h0c00, 16'h0000, 16'h0c00, 16'h0c00, 16'h0300, 16'h0000,
                              16'h0c00, 16'h0300, 16'h0c00, 16'h0300, 16'h0c01, 16'h0c00};
    logic [11:0] cws = 12'hcf1;
    integer num_errors = 0;
    integer checks = 0;
    integer cyc = 0;
    integer m;

    fp_mode_control dut (.*);

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cut a hung run short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    end

    task automatic chk(input [63:0] got, input [63:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task end_of_test;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Bus and port drivers
    // ----------------------------------------
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask

    task automatic cwl(input [15:0] v, input slow);
        cw_load_value <= v;
        cw_load_valid <= 1'b1;
        do @(posedge clk); while (!cw_load_ready_q);
        cw_load_valid <= 1'b0;
        @(posedge clk);
        chk(x87_cw_q, v);
        chk(cw_load_ready_q, !slow);
    endtask

    task automatic opr(input dbl, input [63:0] a, input [63:0] r, input [1:0] uf, input ov);
        op_valid <= 1'b1;
        op_double <= dbl;
        op_a <= a;
        op_b <= r;
        res_valid <= 1'b1;
        res_double <= dbl;
        res_value <= r;
        res_underflow <= uf;
        res_overflow <= ov;
        @(posedge clk);
        op_valid <= 1'b0;
        res_valid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic xr(input [17:0] e, input [1:0] ef);
        x87_res_valid <= 1'b1;
        x87_res_exp <= e;
        @(posedge clk);
        x87_res_valid <= 1'b0;
        @(posedge clk);
        chk({x87_ovf_q, x87_unf_q}, ef);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {reset, ce, pipe_empty} <= 3'b111;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        {op_valid, op_double, res_valid, res_double, res_overflow, res_underflow} <= 7'h00;
        {op_a, op_b, res_value} <= 192'h0;
        {cw_load_valid, cw_load_value, cvt_valid, cvt_truncate} <= 19'h0;
        {x87_res_valid, x87_res_exp} <= 19'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(`OFS_SIMD_CSW, 32'h0, `RESP_OKAY);
        rd(`OFS_X87_CW, 32'h0, `RESP_OKAY);
        rd(`OFS_INT_STATUS, 32'h0, `RESP_OKAY);
        rd(8'h18, 32'h0, `RESP_SLVERR);
        rd(`OFS_INT_CLEAR, 32'h0, `RESP_SLVERR);
        wr(8'h18, 32'h1, `RESP_SLVERR);
        for (m = 0; m < 4; m = m + 1) begin
            wr(`OFS_SIMD_CSW, m, `RESP_OKAY);
            rd(`OFS_SIMD_CSW, m, `RESP_OKAY);
            opr(1'b1, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0003, 2'b01, 1'b0);
            chk(opc_a_q, m[1] ? 64'h8000_0000_0000_0000 : 64'h8000_0000_0000_0001);
            chk(opc_b_q, m[1] ? 64'h8000_0000_0000_0000 : 64'h8000_0000_0000_0003);
            chk(opc_valid_q, 1'b1);
            chk(resc_value_q, m[0] ? 64'h8000_0000_0000_0000 : 64'h8000_0000_0000_0003);
            opr(1'b0, 64'h0000_0001_8000_0002, 64'h0000_0003_8000_0004, 2'b11, 1'b0);
            chk(opc_a_q, m[1] ? 64'h0000_0000_8000_0000 : 64'h0000_0001_8000_0002);
            chk(resc_value_q, m[0] ? 64'h0000_0000_8000_0000 : 64'h0000_0003_8000_0004);
            opr(1'b1, 64'h3ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000, 2'b00, 1'b1);
            chk(resc_value_q, 64'h7ff0_0000_0000_0000);
        end
        // Mode write must wait for the pipe to drain
        pipe_empty <= 1'b0;
        fork
            wr(`OFS_SIMD_CSW, 32'h0, `RESP_OKAY);
            begin
                repeat (8) @(posedge clk);
                chk(issue_stall_q, 1'b1);
                chk(s_axi_bvalid, 1'b0);
                pipe_empty <= 1'b1;
            end
        join
        for (m = 0; m < 12; m = m + 1)
            cwl(cwv[m], cws[m]);
        rd(`OFS_SLOW_COUNT, 32'h7, `RESP_OKAY);
        wr(`OFS_X87_CW, 32'hffff, `RESP_OKAY);
        rd(`OFS_X87_CW, 32'h0c00, `RESP_OKAY);
        cwl(16'h0800, 1'b1);
        for (m = 0; m < 2; m = m + 1) begin
            cvt_valid <= 1'b1;
            cvt_truncate <= m[0];
            @(posedge clk);
            cvt_valid <= 1'b0;
            @(posedge clk);
            chk(cvt_round_q, m[0] ? `RC_TRUNCATE : 2'h2);
        end
        xr(18'h07fff, 2'b10);
        xr(18'h07ffe, 2'b00);
        xr(18'h00000, 2'b01);
        xr(18'h3ffff, 2'b01);
        rd(`OFS_INT_STATUS, 32'h3f, `RESP_OKAY);
        chk(irq_q, 1'b0);
        wr(`OFS_INT_ENABLE, 32'h10, `RESP_OKAY);
        rd(`OFS_INT_ENABLE, 32'h10, `RESP_OKAY);
        chk(irq_q, 1'b1);
        wr(`OFS_INT_CLEAR, 32'h10, `RESP_OKAY);
        rd(`OFS_INT_STATUS, 32'h2f, `RESP_OKAY);
        chk(irq_q, 1'b0);
        wr(`OFS_INT_CLEAR, 32'h3f, `RESP_OKAY);
        rd(`OFS_INT_STATUS, 32'h0, `RESP_OKAY);
        // Clock enable low holds every flop
        ce <= 1'b0;
        x87_res_valid <= 1'b1;
        x87_res_exp <= 18'h07fff;
        repeat (2) @(posedge clk);
        chk(x87_ovf_q, 1'b0);
        ce <= 1'b1;
        @(posedge clk);
        x87_res_valid <= 1'b0;
        @(posedge clk);
        chk(x87_ovf_q, 1'b1);
        rd(`OFS_INT_STATUS, 32'h10, `RESP_OKAY);
        chk(irq_q, 1'b1);
        end_of_test;
    end
endmodule
